// ### hdl/cfg_prot_pkg.sv
// Constants for the configuration protection block: register indices, field
// positions, implemented-bit masks, protected address ranges and bus answers.
// Assumes registers are reached over AXI4-Lite at byte address four times the index.
// Operation
// [R1] Debug bit low dedicates port B pins six, seven.
// [R2] Low-voltage programming entry only while its enable is set.
// [R3] Stack full or underflow resets only when enabled.
// [R4] Read guard three low protects block three.
// [R5] Read guard two low protects block two.
// [R6] Read guard one low protects block one.
// [R7] Read guard zero low protects block zero.
// [R8] EEPROM read guard low protects data EEPROM.
// [R9] Write guard three low blocks block three writes.
// [R10] Write guard two low blocks block two writes.
// [R11] Write guard one low blocks block one writes.
// [R12] Write guard zero low blocks block zero writes.
// [R13] Unimplemented configuration bits always read as zero.
// [R14] Boot write guard low blocks boot block writes.
// [R15] Settings write guard low blocks configuration writes.
// [R16] EEPROM write guard low blocks EEPROM writes.
// [R17] Boot read guard low protects the boot block.
// [R18] Guard bits clear only; bulk erase sets them.
package cfg_prot_pkg;
	localparam logic [23:0] IDX_DBG = 24'h300006;
	localparam logic [23:0] IDX_RD_PROG = 24'h300008;
	localparam logic [23:0] IDX_RD_BOOT = 24'h300009;
	localparam logic [23:0] IDX_WR_PROG = 24'h30000a;
	localparam logic [23:0] IDX_WR_BOOT = 24'h30000b;
	localparam logic [23:0] IDX_ERASE = 24'h300010;
	localparam logic [23:0] IDX_STATUS = 24'h300011;
	localparam logic [7:0] MASK_DBG = 8'h85;
	localparam logic [7:0] MASK_PROG = 8'h0f;
	localparam logic [7:0] MASK_RD_BOOT = 8'hc0;
	localparam logic [7:0] MASK_WR_BOOT = 8'he0;
	localparam int DBG_BIT = 7;
	localparam int LVP_BIT = 2;
	localparam int STK_BIT = 0;
	localparam int EE_RD_BIT = 7;
	localparam int BOOT_RD_BIT = 6;
	localparam int EE_WR_BIT = 7;
	localparam int BOOT_WR_BIT = 6;
	localparam int CFG_WR_BIT = 5;
	localparam int ERASE_BIT = 0;
	// Ranges 0..3 are program blocks, 4 the boot block, 5 the configuration space.
	localparam int NUM_RANGES = 6;
	localparam int RANGE_BOOT = 4;
	localparam int RANGE_CFG = 5;
	localparam logic [23:0] RANGE_LO [NUM_RANGES] = '{24'h000800, 24'h004000, 24'h008000,
		24'h00c000, 24'h000000, 24'h300000};
	localparam logic [23:0] RANGE_HI [NUM_RANGES] = '{24'h003fff, 24'h007fff, 24'h00bfff,
		24'h00ffff, 24'h0007ff, 24'h3000ff};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ### hdl/pin_sync.sv
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the input is a slow level; only the second stage may be read.
module pin_sync (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Level in and out.
	input wire logic pin_in,
	output logic level_out
);
	logic meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			level_out <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			level_out <= meta_reg;
		end
	end
endmodule // pin_sync

// ### hdl/range_guard.sv
// Address window compare for one protected memory range.
// Assumes the bounds are inclusive and lo is not above hi.
module range_guard #(
	parameter logic [23:0] LO = 24'h000000,
	parameter logic [23:0] HI = 24'h0007ff
) (
	// Address under test and the match.
	input wire logic [23:0] addr,
	output logic hit
);
	// The range includes both ends.
	assign hit = (addr >= LO) && (addr <= HI);
endmodule // range_guard

// ### hdl/config_protection_bits.sv
// Configuration protection bytes: debug pin use, low-voltage programming entry,
// stack fault reset, read guards over program, boot and EEPROM, and write guards over those and settings.
// Assumes an AXI4-Lite master on sys_clk and a core that presents accesses to check.
module config_protection_bits (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite write channels.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Memory access check.
	input wire logic access_valid,
	input wire logic [23:0] access_addr,
	input wire logic access_write,
	input wire logic access_eeprom,
	input wire logic access_external,
	output logic access_done,
	output logic access_grant,
	// Pins and core controls.
	input wire logic lvp_entry_pin,
	output logic lvp_mode_active,
	output logic port_b_pins_debug,
	input wire logic stack_full,
	input wire logic stack_underflow,
	output logic stack_reset_req
);
	logic [7:0] cfg_dbg_reg;
	logic [7:0] rd_prog_reg;
	logic [7:0] rd_boot_reg;
	logic [7:0] wr_prog_reg;
	logic [7:0] wr_boot_reg;
	logic aw_held_reg;
	logic [31:0] aw_addr_reg;
	logic w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg;
	logic bvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic rvalid_reg;
	logic access_done_reg;
	logic access_grant_reg;
	logic last_refused_reg;
	logic lvp_mode_reg;
	logic debug_pins_reg;
	logic stack_reset_reg;
	logic lvp_req_sync;
	logic [cfg_prot_pkg::NUM_RANGES-1:0] range_hit;
	logic wr_go;
	logic [23:0] wr_idx;
	logic wr_mapped;
	logic wr_refused;
	logic [1:0] wr_resp;
	logic wr_store;
	logic erase_req;
	logic [7:0] wr_byte;
	logic [23:0] rd_idx;
	logic rd_mapped;
	logic [7:0] rd_byte;
	logic deny_write;
	logic deny_read;

	// One comparator per protected range.
	generate
		for (genvar i = 0; i < cfg_prot_pkg::NUM_RANGES; i++) begin : g_range
			range_guard #(
				.LO(cfg_prot_pkg::RANGE_LO[i]),
				.HI(cfg_prot_pkg::RANGE_HI[i])
			) u_range (
				.addr(access_addr),
				.hit(range_hit[i])
			);
		end
	endgenerate

	// The programming-entry request comes from a pin.
	pin_sync u_lvp_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(lvp_entry_pin),
		.level_out(lvp_req_sync)
	);

	// Each channel is ready while its slot is empty and no response is pending.
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign access_done = access_done_reg;
	assign access_grant = access_grant_reg;
	assign lvp_mode_active = lvp_mode_reg;
	assign port_b_pins_debug = debug_pins_reg;
	assign stack_reset_req = stack_reset_reg;

	// Write decode; the erase register stays open so a locked part can recover.
	always_comb begin
		wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
		wr_idx = aw_addr_reg[25:2];
		wr_byte = w_data_reg[7:0];
		wr_mapped = (aw_addr_reg[31:26] == 6'h00) && (wr_idx == cfg_prot_pkg::IDX_DBG ||
			wr_idx == cfg_prot_pkg::IDX_RD_PROG || wr_idx == cfg_prot_pkg::IDX_RD_BOOT ||
			wr_idx == cfg_prot_pkg::IDX_WR_PROG || wr_idx == cfg_prot_pkg::IDX_WR_BOOT ||
			wr_idx == cfg_prot_pkg::IDX_ERASE || wr_idx == cfg_prot_pkg::IDX_STATUS);
		wr_refused = (wr_idx == cfg_prot_pkg::IDX_STATUS) || ((wr_idx != cfg_prot_pkg::IDX_ERASE)
			&& !wr_boot_reg[cfg_prot_pkg::CFG_WR_BIT]); // R15
		if (!wr_mapped) begin
			wr_resp = cfg_prot_pkg::RESP_DECERR;
		end else if (wr_refused) begin
			wr_resp = cfg_prot_pkg::RESP_SLVERR;
		end else begin
			wr_resp = cfg_prot_pkg::RESP_OKAY;
		end
		wr_store = wr_go && wr_mapped && !wr_refused && w_strb_reg[0];
		erase_req = wr_store && (wr_idx == cfg_prot_pkg::IDX_ERASE) &&
			wr_byte[cfg_prot_pkg::ERASE_BIT];
	end

	// Address and data are taken in either order and held until the write is done.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 32'h00000000;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= cfg_prot_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_resp;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Guard bits only clear on write; erase returns every implemented bit to one.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_dbg_reg <= cfg_prot_pkg::MASK_DBG;
			rd_prog_reg <= cfg_prot_pkg::MASK_PROG;
			rd_boot_reg <= cfg_prot_pkg::MASK_RD_BOOT;
			wr_prog_reg <= cfg_prot_pkg::MASK_PROG;
			wr_boot_reg <= cfg_prot_pkg::MASK_WR_BOOT;
		end else if (erase_req) begin
			cfg_dbg_reg <= cfg_prot_pkg::MASK_DBG;
			rd_prog_reg <= cfg_prot_pkg::MASK_PROG; // R18
			rd_boot_reg <= cfg_prot_pkg::MASK_RD_BOOT;
			wr_prog_reg <= cfg_prot_pkg::MASK_PROG;
			wr_boot_reg <= cfg_prot_pkg::MASK_WR_BOOT;
		end else if (wr_store) begin
			case (wr_idx)
				cfg_prot_pkg::IDX_DBG: cfg_dbg_reg <= wr_byte & cfg_prot_pkg::MASK_DBG; // R13
				cfg_prot_pkg::IDX_RD_PROG: rd_prog_reg <= rd_prog_reg & wr_byte; // R18
				cfg_prot_pkg::IDX_RD_BOOT: rd_boot_reg <= rd_boot_reg & wr_byte; // R18
				cfg_prot_pkg::IDX_WR_PROG: wr_prog_reg <= wr_prog_reg & wr_byte; // R18
				cfg_prot_pkg::IDX_WR_BOOT: wr_boot_reg <= wr_boot_reg & wr_byte; // R18
				default: cfg_dbg_reg <= cfg_dbg_reg;
			endcase
		end
	end

	// Read decode; stored bytes never hold unimplemented bits, upper lanes are zero.
	always_comb begin
		rd_idx = s_axi_araddr[25:2];
		rd_mapped = (s_axi_araddr[31:26] == 6'h00);
		case (rd_idx)
			cfg_prot_pkg::IDX_DBG: rd_byte = cfg_dbg_reg; // R13
			cfg_prot_pkg::IDX_RD_PROG: rd_byte = rd_prog_reg;
			cfg_prot_pkg::IDX_RD_BOOT: rd_byte = rd_boot_reg;
			cfg_prot_pkg::IDX_WR_PROG: rd_byte = wr_prog_reg;
			cfg_prot_pkg::IDX_WR_BOOT: rd_byte = wr_boot_reg;
			cfg_prot_pkg::IDX_ERASE: rd_byte = 8'h00;
			cfg_prot_pkg::IDX_STATUS: rd_byte = {5'h00, last_refused_reg, debug_pins_reg,
				lvp_mode_reg};
			default: begin
				rd_byte = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// A read answers one cycle after its address is taken.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= cfg_prot_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= {24'h000000, rd_byte};
			rresp_reg <= rd_mapped ? cfg_prot_pkg::RESP_OKAY : cfg_prot_pkg::RESP_DECERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Write and external-read refusal per range; EEPROM accesses ignore the address.
	always_comb begin
		if (access_eeprom) begin
			deny_write = !wr_boot_reg[cfg_prot_pkg::EE_WR_BIT]; // R16
			deny_read = !rd_boot_reg[cfg_prot_pkg::EE_RD_BIT]; // R8
		end else begin
			deny_write = |(range_hit[3:0] & ~wr_prog_reg[3:0]) || // R9 R10 R11 R12 R14 R15
				(range_hit[cfg_prot_pkg::RANGE_BOOT] && !wr_boot_reg[cfg_prot_pkg::BOOT_WR_BIT]) ||
				(range_hit[cfg_prot_pkg::RANGE_CFG] && !wr_boot_reg[cfg_prot_pkg::CFG_WR_BIT]);
			deny_read = |(range_hit[3:0] & ~rd_prog_reg[3:0]) || // R4 R5 R6 R7
				(range_hit[cfg_prot_pkg::RANGE_BOOT] &&
				!rd_boot_reg[cfg_prot_pkg::BOOT_RD_BIT]); // R17
		end
	end

	// Each checked access is answered the next cycle with grant or refusal.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			access_done_reg <= 1'b0;
			access_grant_reg <= 1'b0;
			last_refused_reg <= 1'b0;
		end else begin
			access_done_reg <= access_valid;
			access_grant_reg <= access_valid && (access_write ? !deny_write :
				!(access_external && deny_read));
			if (access_valid) begin
				last_refused_reg <= access_write ? deny_write : (access_external && deny_read);
			end
		end
	end

	// Pin use, programming entry and stack reset follow the debug byte.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			debug_pins_reg <= 1'b0;
			lvp_mode_reg <= 1'b0;
			stack_reset_reg <= 1'b0;
		end else begin
			debug_pins_reg <= !cfg_dbg_reg[cfg_prot_pkg::DBG_BIT]; // R1
			lvp_mode_reg <= lvp_req_sync && cfg_dbg_reg[cfg_prot_pkg::LVP_BIT]; // R2
			stack_reset_reg <= cfg_dbg_reg[cfg_prot_pkg::STK_BIT] &&
				(stack_full || stack_underflow); // R3
		end
	end

	// Checks on the protection behaviour.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_refused;
		access_done && !access_grant;
	endsequence

	property p_blocked(logic hit, logic wr, logic guard);
		access_valid && !access_eeprom && hit && (access_write == wr) && !guard &&
			(wr || access_external) |=> s_refused;
	endproperty

	a_debug_pin_use: assert property (port_b_pins_debug == !$past(cfg_dbg_reg[7])) // R1
		else $error("debug pins not dedicated");
	a_lvp_entry_refused: assert property (!cfg_dbg_reg[2] && $stable(cfg_dbg_reg) |=>
		!lvp_mode_active) // R2
		else $error("programming entry accepted while disabled");
	a_stack_fault_reset: assert property ((stack_full || stack_underflow) |=>
		(stack_reset_req == $past(cfg_dbg_reg[0]))) // R3
		else $error("stack reset does not follow its enable");
	a_block3_read: assert property (p_blocked(range_hit[3], 1'b0, rd_prog_reg[3])) // R4
		else $error("block three read not refused");
	a_block2_read: assert property (p_blocked(range_hit[2], 1'b0, rd_prog_reg[2])) // R5
		else $error("block two read not refused");
	a_block1_read: assert property (p_blocked(range_hit[1], 1'b0, rd_prog_reg[1])) // R6
		else $error("block one read not refused");
	a_block0_read: assert property (p_blocked(range_hit[0], 1'b0, rd_prog_reg[0])) // R7
		else $error("block zero read not refused");
	a_eeprom_read: assert property (access_valid && access_eeprom && !access_write &&
		access_external && !rd_boot_reg[7] |=> s_refused) // R8
		else $error("EEPROM read not refused");
	a_block3_write: assert property (p_blocked(range_hit[3], 1'b1, wr_prog_reg[3])) // R9
		else $error("block three write not refused");
	a_block2_write: assert property (p_blocked(range_hit[2], 1'b1, wr_prog_reg[2])) // R10
		else $error("block two write not refused");
	a_block1_write: assert property (p_blocked(range_hit[1], 1'b1, wr_prog_reg[1])) // R11
		else $error("block one write not refused");
	a_block0_write: assert property (p_blocked(range_hit[0], 1'b1, wr_prog_reg[0])) // R12
		else $error("block zero write not refused");
	a_unused_bits_zero: assert property (s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000)
		&& ((cfg_dbg_reg & ~8'h85) == 8'h00)) // R13
		else $error("unimplemented bits read nonzero");
	a_boot_write: assert property (p_blocked(range_hit[4], 1'b1, wr_boot_reg[6])) // R14
		else $error("boot write not refused");
	a_settings_write: assert property (wr_go && wr_idx != 24'h300010 && !wr_boot_reg[5]
		|=> s_axi_bvalid && s_axi_bresp != 2'h0 && $stable(rd_prog_reg)) // R15
		else $error("settings write not refused");
	a_eeprom_write: assert property (access_valid && access_eeprom && access_write &&
		!wr_boot_reg[7] |=> s_refused) // R16
		else $error("EEPROM write not refused");
	a_boot_read: assert property (p_blocked(range_hit[4], 1'b0, rd_boot_reg[6])) // R17
		else $error("boot read not refused");
	a_guard_set_erase: assert property ((|(wr_prog_reg & ~$past(wr_prog_reg)) ||
		|(rd_prog_reg & ~$past(rd_prog_reg))) |-> $past(erase_req)) // R18
		else $error("guard bit set without erase");
endmodule // config_protection_bits

// ### tb/prog_master.sv
// Programmer model: an AXI4-Lite master that writes and reads the configuration bytes.
// Assumes the slave answers each channel in its own time; only the bench watchdog ends a wait.
module prog_master (
	// Clock.
	input wire logic sys_clk,
	// Write channels.
	output logic [31:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels.
	output logic [31:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// Every request line starts idle.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// One write; released lines show the inverse so stale values are never trusted.
	task automatic write_word(input logic [31:0] addr, input logic [31:0] data,
		output logic [1:0] resp);
		logic aw_done;
		logic w_done;
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_hs = 1'b0;
		@(posedge sys_clk);
		awaddr <= addr;
		wdata <= data;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge sys_clk);
			aw_hs = !aw_done && awready;
			w_hs = !w_done && wready;
			@(posedge sys_clk);
			if (aw_hs) begin
				awvalid <= 1'b0;
				awaddr <= ~addr;
				aw_done = 1'b1;
			end
			if (w_hs) begin
				wvalid <= 1'b0;
				wdata <= ~data;
				w_done = 1'b1;
			end
		end
		while (!b_hs) begin
			@(negedge sys_clk);
			b_hs = bvalid;
			resp = bresp;
			@(posedge sys_clk);
		end
		bready <= 1'b0;
	endtask

	// One read; data and response are taken at the edge where rvalid is seen.
	task automatic read_word(input logic [31:0] addr, output logic [31:0] data,
		output logic [1:0] resp);
		logic ar_hs;
		logic r_hs;
		ar_hs = 1'b0;
		r_hs = 1'b0;
		@(posedge sys_clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ar_hs) begin
			@(negedge sys_clk);
			ar_hs = arready;
			@(posedge sys_clk);
		end
		arvalid <= 1'b0;
		araddr <= ~addr;
		while (!r_hs) begin
			@(negedge sys_clk);
			r_hs = rvalid;
			data = rdata;
			resp = rresp;
			@(posedge sys_clk);
		end
		rready <= 1'b0;
	endtask
endmodule // prog_master

// ### tb/config_protection_bits_tb.sv
// Bench for the configuration protection block: bus tasks, guard table sweep, pin checks.
// Assumes prog_master drives the register bus and this module drives the access and pin inputs.
module config_protection_bits_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic access_valid, access_write, access_eeprom, access_external, access_done, access_grant;
	logic [23:0] access_addr;
	logic lvp_entry_pin, lvp_mode_active, port_b_pins_debug;
	logic stack_full, stack_underflow, stack_reset_req;
	int failures, n_tests;

	// Guard table: register, value with one guard cleared, write kind, probe that it blocks.
	localparam logic [23:0] G_IDX [13] = '{24'h300008, 24'h300008, 24'h300008, 24'h300008,
		24'h300009, 24'h300009, 24'h30000a, 24'h30000a, 24'h30000a, 24'h30000a,
		24'h30000b, 24'h30000b, 24'h30000b};
	localparam logic [7:0] G_VAL [13] = '{8'h0e, 8'h0d, 8'h0b, 8'h07, 8'h40, 8'h80,
		8'h0e, 8'h0d, 8'h0b, 8'h07, 8'h60, 8'ha0, 8'hc0};
	localparam logic [12:0] G_WR = 13'h1fc0;
	localparam int G_PRB [13] = '{0, 1, 2, 3, 6, 4, 0, 1, 2, 3, 6, 4, 5};

	// Clock at 50 MHz.
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;

	prog_master prog_u (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	config_protection_bits dut_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.access_valid(access_valid), .access_addr(access_addr), .access_write(access_write),
		.access_eeprom(access_eeprom), .access_external(access_external),
		.access_done(access_done), .access_grant(access_grant),
		.lvp_entry_pin(lvp_entry_pin), .lvp_mode_active(lvp_mode_active),
		.port_b_pins_debug(port_b_pins_debug), .stack_full(stack_full),
		.stack_underflow(stack_underflow), .stack_reset_req(stack_reset_req));

	function automatic logic [31:0] baddr(input logic [23:0] idx);
		return {6'h00, idx, 2'h0};
	endfunction

	// Compare tasks, one for each kind of result.
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: response %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// Bus accesses with their expected answers.
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		prog_u.write_word(a, d, r);
		cmp_resp(r, er);
	endtask
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		prog_u.read_word(a, d, r);
		cmp_data(d, ed);
		cmp_resp(r, er);
	endtask

	// Probes 0..5 are ranges (low bound for reads, high for writes), 6 EEPROM, 7 unguarded.
	task automatic probe(input int p, input logic wr, input logic ext, input logic exp);
		@(posedge sys_clk);
		access_valid <= 1'b1;
		access_addr <= (p < 6) ? (wr ? cfg_prot_pkg::RANGE_HI[p] : cfg_prot_pkg::RANGE_LO[p])
			: ((p == 6) ? 24'h000000 : 24'h200000);
		access_write <= wr;
		access_eeprom <= (p == 6);
		access_external <= ext;
		@(posedge sys_clk);
		access_valid <= 1'b0;
		@(negedge sys_clk);
		cmp_flag(access_done, 1'b1);
		cmp_flag(access_grant, exp);
	endtask

	// One stack fault cycle, then the reset request one cycle later.
	task automatic stack_try(input logic full, input logic under, input logic exp);
		@(posedge sys_clk);
		stack_full <= full;
		stack_underflow <= under;
		@(posedge sys_clk);
		stack_full <= 1'b0;
		stack_underflow <= 1'b0;
		@(negedge sys_clk);
		cmp_flag(stack_reset_req, exp);
	endtask

	// Raises the entry pin and looks three edges later.
	task automatic lvp_try(input logic exp);
		@(posedge sys_clk);
		lvp_entry_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		cmp_flag(lvp_mode_active, exp);
		@(posedge sys_clk);
		lvp_entry_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog well beyond the fewer than one thousand cycles the tests need.
	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		summarize();
	end

	// Main sequence.
	initial begin
		failures = 0;
		n_tests = 0;
		rst = 1'b1;
		{access_valid, access_write, access_eeprom, access_external} = '0;
		access_addr = '0;
		{lvp_entry_pin, stack_full, stack_underflow} = '0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		axi_rd(baddr(24'h300006), 32'h85, 2'h0);
		axi_rd(baddr(24'h300008), 32'h0f, 2'h0);
		axi_rd(baddr(24'h300009), 32'hc0, 2'h0);
		axi_rd(baddr(24'h30000a), 32'h0f, 2'h0);
		axi_rd(baddr(24'h30000b), 32'he0, 2'h0);
		axi_rd(32'h00000100, 32'h0, 2'h3);
		axi_wr(32'h00000100, 32'h0, 2'h3);
		$display("test reset done");
		cmp_flag(port_b_pins_debug, 1'b0);
		axi_wr(baddr(24'h300006), 32'h7a, 2'h0);
		axi_rd(baddr(24'h300006), 32'h00, 2'h0);
		cmp_flag(port_b_pins_debug, 1'b1);
		axi_rd(baddr(24'h300011), 32'h02, 2'h0);
		axi_wr(baddr(24'h300011), 32'h0, 2'h2);
		stack_try(1'b1, 1'b0, 1'b0);
		lvp_try(1'b0);
		axi_wr(baddr(24'h300006), 32'hff, 2'h0);
		axi_rd(baddr(24'h300006), 32'h85, 2'h0);
		cmp_flag(port_b_pins_debug, 1'b0);
		stack_try(1'b1, 1'b0, 1'b1);
		stack_try(1'b0, 1'b1, 1'b1);
		lvp_try(1'b1);
		$display("test pins done");
		for (int g = 0; g < 13; g++) begin
			axi_wr(baddr(24'h300010), 32'h1, 2'h0);
			axi_wr(baddr(G_IDX[g]), {24'h0, G_VAL[g]}, 2'h0);
			axi_wr(baddr(G_IDX[g]), 32'hff, (g == 12) ? 2'h2 : 2'h0);
			axi_rd(baddr(G_IDX[g]), {24'h0, G_VAL[g]}, 2'h0);
			for (int p = 0; p < 8; p++) begin
				probe(p, G_WR[g], 1'b1, p != G_PRB[g]);
				probe(p, !G_WR[g], 1'b1, 1'b1);
			end
			probe(G_PRB[g], 1'b0, 1'b0, 1'b1);
		end
		axi_wr(baddr(24'h300006), 32'h00, 2'h2);
		axi_wr(baddr(24'h300010), 32'h1, 2'h0);
		axi_rd(baddr(24'h30000b), 32'he0, 2'h0);
		$display("test guards done");
		summarize();
	end
endmodule // config_protection_bits_tb
